//--- rcr_params.svh
`ifndef RCR_PARAMS_SVH
`define RCR_PARAMS_SVH

// ==========================================
// Register offsets and bank geometry
`define RCR_NREG          6
`define RCR_OFF_SW_MODE_B 6'h1d
`define RCR_OFF_VSEL_A    6'h1e
`define RCR_OFF_VSEL_B    6'h1f
`define RCR_OFF_EN_MODE_A 6'h20
`define RCR_OFF_EN_MODE_B 6'h21
`define RCR_OFF_MISC      6'h22

// ==========================================
// Writable bits per register
`define RCR_WM_SW_MODE_B  24'h103f3f
`define RCR_WM_VSEL_A     24'h075ff3
`define RCR_WM_VSEL_B     24'h0001fc
`define RCR_WM_EN_MODE_A  24'h1ffe3f
`define RCR_WM_EN_MODE_B  24'h1ff3ef
`define RCR_WM_MISC       24'h23bfc1

// ==========================================
// Bits restored by the main reset
`define RCR_RM_SW_MODE_B  24'h000f0f
`define RCR_RM_VSEL_A     24'h074003
`define RCR_RM_VSEL_B     24'h0001fc
`define RCR_RM_EN_MODE_A  24'h1f6c37
`define RCR_RM_EN_MODE_B  24'h1ff3ef
`define RCR_RM_MISC       24'h23bfc1

// ==========================================
// Reset values
`define RCR_DF_SW_MODE_B  24'h000a0a
`define RCR_DF_VSEL_A     24'h024000
`define RCR_DF_VSEL_B     24'h0001d8
`define RCR_DF_EN_MODE_A  24'h000000
`define RCR_DF_EN_MODE_B  24'h000000
`define RCR_DF_MISC       24'h218000

// ==========================================
// Field positions
`define RCR_SW3_MODE_LSB  0
`define RCR_SW3_HOLD_BIT  4
`define RCR_SW3_UOFF_BIT  5
`define RCR_SW4_MODE_LSB  8
`define RCR_SW4_HOLD_BIT  12
`define RCR_SW4_UOFF_BIT  13
`define RCR_BOOST_EN_BIT  20
`define RCR_SCP_EN_BIT    0
`define RCR_LDO3_EXT_BIT  3
`define RCR_CAM_EXT_BIT   9
`define RCR_VID_EN_BIT    12
`define RCR_VID_MODE_BIT  14
`define RCR_NSUP          15
`define RCR_SUP_REG '{3'h3,3'h3,3'h3,3'h3,3'h3,3'h3,3'h4,3'h4,3'h4,3'h4,3'h4,3'h5,3'h5,3'h5,3'h5}
`define RCR_SUP_POS '{5'h0,5'h3,5'h9,5'hc,5'hf,5'h12,5'h0,5'h6,5'hc,5'hf,5'h12,5'h6,5'h8,5'ha,5'hc}

// ==========================================
// Mode codes and sequencer timing
`define RCR_MODE_PWM      4'ha
`define RCR_MODE_OFF      4'h0
`define RCR_SEQ_SETTLE    3'h4

`endif

//--- rcr_pkg.sv
package rcr_pkg;

  // ==========================================
  // Types
  typedef logic [23:0] rcr_word_t;

  typedef enum logic [1:0] {
    st_idle   = 2'h0,
    st_settle = 2'h1,
    st_load   = 2'h3,
    st_done   = 2'h2
  } rcr_seq_state_t;

endpackage : rcr_pkg

//--- rcr_startup_seq.sv
`timescale 1ns/1ns
`include "rcr_params.svh"
module rcr_startup_seq
  import rcr_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic [1:0] mode_sel_pin,
  output logic            load,
  output logic [3:0]      mode3,
  output logic [3:0]      mode4,
  output logic            done
);

  logic [1:0]     msel_s1;
  logic [1:0]     msel_s2;
  logic [1:0]     msel_s3;
  logic [1:0]     msel_lvl;
  logic [2:0]     settle;
  rcr_seq_state_t state;
  rcr_seq_state_t next_state;

  // ==========================================
  // Strap synchroniser, accepted when stages agree
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      msel_s1 <= 2'h0;
      msel_s2 <= 2'h0;
      msel_s3 <= 2'h0;
    end else if (ce) begin
      msel_s1 <= mode_sel_pin;
      msel_s2 <= msel_s1;
      msel_s3 <= msel_s2;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      msel_lvl <= 2'h0;
    end else if (ce && msel_s2 == msel_s3) begin
      msel_lvl <= msel_s3;
    end
  end

  // ==========================================
  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      st_idle:   next_state = st_settle;
      st_settle: if (settle == `RCR_SEQ_SETTLE) next_state = st_load;
      st_load:   next_state = st_done;
      st_done:   next_state = st_done;
      default:   next_state = st_idle;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= st_idle;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Waits out the strap synchroniser before trusting the level
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      settle <= 3'h0;
    end else if (ce && state == st_settle) begin
      settle <= settle + 3'h1;
    end
  end

  // Enabled switchers start in forced PWM for normal and standby
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode3 <= `RCR_MODE_OFF;
      mode4 <= `RCR_MODE_OFF;
    end else if (ce && state == st_settle && next_state == st_load) begin
      mode3 <= (msel_lvl != 2'h0) ? `RCR_MODE_PWM : `RCR_MODE_OFF;
      mode4 <= msel_lvl[1] ? `RCR_MODE_PWM : `RCR_MODE_OFF;
    end
  end

  assign load = (state == st_load) && ce;
  assign done = (state == st_done);

endmodule : rcr_startup_seq

//--- rcr_regbank.sv
// ==========================================
// Behaviour
// - Startup sequencer reloads each switcher mode field from the power-up mode select.
// - An enabled switcher starts in forced PWM, normal and standby, until rewritten.
// - Memory-hold and user-off bits clear only on power-off reset.
// - Short-circuit protection enable bit clears to zero on main reset.
// - Standby-control bit makes a regulator follow the standby input.
// - Two regulators have an external pass transistor select bit, reset zero.
// - Four general outputs have enable and standby bits, cleared by main reset.
// - Video regulator enable, standby and mode bits clear on main reset.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
`include "rcr_params.svh"
module rcr_regbank
  import rcr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        power_off_reset_low,
  input  wire logic        standby_pin,
  input  wire logic [1:0]  power_up_mode_select,
  input  wire logic [5:0]  addr,
  input  wire logic [23:0] wr_data,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic [23:0]      rd_data,
  output logic [3:0]       third_switcher_op_mode,
  output logic [3:0]       fourth_switcher_op_mode,
  output logic             third_switcher_memory_hold,
  output logic             fourth_switcher_memory_hold,
  output logic             third_switcher_user_off,
  output logic             fourth_switcher_user_off,
  output logic             boost_switcher_enable,
  output logic [23:0]      voltage_select_a,
  output logic [23:0]      voltage_select_b,
  output logic             short_circuit_protect_enable,
  output logic             general_ldo3_external_pass,
  output logic             camera_ldo_external_pass,
  output logic             video_ldo_op_mode,
  output logic [14:0]      supply_on,
  output logic             startup_done
);

  // ==========================================
  // Bank description
  localparam int        NREG = `RCR_NREG;
  localparam int        NSUP = `RCR_NSUP;
  localparam int        IDX_SW   = 0;
  localparam int        IDX_VIDB = 4;
  localparam int        IDX_MISC = 5;

  localparam logic [5:0] OFF [0:NREG-1] = '{
    `RCR_OFF_SW_MODE_B, `RCR_OFF_VSEL_A, `RCR_OFF_VSEL_B,
    `RCR_OFF_EN_MODE_A, `RCR_OFF_EN_MODE_B, `RCR_OFF_MISC
  };

  localparam rcr_word_t WM [0:NREG-1] = '{
    `RCR_WM_SW_MODE_B, `RCR_WM_VSEL_A, `RCR_WM_VSEL_B,
    `RCR_WM_EN_MODE_A, `RCR_WM_EN_MODE_B, `RCR_WM_MISC
  };

  localparam rcr_word_t RM [0:NREG-1] = '{
    `RCR_RM_SW_MODE_B, `RCR_RM_VSEL_A, `RCR_RM_VSEL_B,
    `RCR_RM_EN_MODE_A, `RCR_RM_EN_MODE_B, `RCR_RM_MISC
  };

  localparam rcr_word_t DF [0:NREG-1] = '{
    `RCR_DF_SW_MODE_B, `RCR_DF_VSEL_A, `RCR_DF_VSEL_B,
    `RCR_DF_EN_MODE_A, `RCR_DF_EN_MODE_B, `RCR_DF_MISC
  };

  localparam logic [2:0] SUP_REG [0:NSUP-1] = `RCR_SUP_REG;
  localparam logic [4:0] SUP_POS [0:NSUP-1] = `RCR_SUP_POS;

  // ==========================================
  // Signals
  rcr_word_t   regs     [0:NREG-1];
  rcr_word_t   next_reg [0:NREG-1];
  rcr_word_t   rd_word;
  logic [14:0] next_supply;
  logic        stby_s1;
  logic        stby_s2;
  logic        stby_s3;
  logic        stby_lvl;
  logic        seq_rst_n;
  logic        seq_load;
  logic [3:0]  seq_mode3;
  logic [3:0]  seq_mode4;

  // ==========================================
  // Startup sequencer
  // Power-off reset is the deeper one, so it restarts the sequencer too
  assign seq_rst_n = rst_n & power_off_reset_low;

  rcr_startup_seq u_seq (
    .core_clk     (core_clk),
    .rst_n        (seq_rst_n),
    .ce           (ce),
    .mode_sel_pin (power_up_mode_select),
    .load         (seq_load),
    .mode3        (seq_mode3),
    .mode4        (seq_mode4),
    .done         (startup_done)
  );

  // ==========================================
  // Register storage
  // Only writable bits ever change, so unused bits stay zero
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    always_comb begin
      next_reg[i] = regs[i];
      if (i == IDX_SW && seq_load) begin
        next_reg[i][`RCR_SW3_MODE_LSB +: 4] = seq_mode3;
        next_reg[i][`RCR_SW4_MODE_LSB +: 4] = seq_mode4;
      end
      // A write in the load cycle wins, software has the last word
      if (wr_stb && addr == OFF[i]) begin
        next_reg[i] = (next_reg[i] & ~WM[i]) | (wr_data & WM[i]);
      end
    end

    // Main reset restores only its own bits; the rest survive it
    always_ff @(posedge core_clk) begin
      if (!power_off_reset_low) begin
        regs[i] <= DF[i];
      end else if (!rst_n) begin
        regs[i] <= (regs[i] & ~RM[i]) | (DF[i] & RM[i]);
      end else if (ce) begin
        regs[i] <= next_reg[i];
      end
    end

    // Reset values sit inside the writable masks, so unused bits never set
    reserved_zero_a: assert property (
      @(posedge core_clk) disable iff (!power_off_reset_low)
      (regs[i] & ~WM[i]) == 24'h000000
    ) else $error("unused register bits hold ones");

    write_land_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !power_off_reset_low)
      ce && wr_stb && addr == OFF[i]
      |=> (regs[i] & WM[i]) == ($past(wr_data) & WM[i])
    ) else $error("register write did not land");

    read_word_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !power_off_reset_low)
      ce && rd_stb && addr == OFF[i] |=> rd_data == $past(regs[i])
    ) else $error("read data differs from register");

    freeze_hold_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !power_off_reset_low)
      !ce |=> $stable(regs[i])
    ) else $error("register changed while clock enable low");
  end

  // ==========================================
  // Read path
  always_comb begin
    rd_word = 24'h000000;
    for (int k = 0; k < NREG; k++) begin
      if (addr == OFF[k]) begin
        rd_word = regs[k];
      end
    end
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n || !power_off_reset_low) begin
      rd_data <= 24'h000000;
    end else if (ce) begin
      rd_data <= rd_stb ? rd_word : 24'h000000;
    end
  end

  // ==========================================
  // Standby input synchroniser
  always_ff @(posedge core_clk) begin
    if (!power_off_reset_low) begin
      stby_s1 <= 1'b0;
      stby_s2 <= 1'b0;
      stby_s3 <= 1'b0;
    end else if (ce) begin
      stby_s1 <= standby_pin;
      stby_s2 <= stby_s1;
      stby_s3 <= stby_s2;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!power_off_reset_low) begin
      stby_lvl <= 1'b0;
    end else if (ce && stby_s2 == stby_s3) begin
      stby_lvl <= stby_s3;
    end
  end

  // ==========================================
  // Supply on/off, regulators then general outputs
  for (genvar j = 0; j < NSUP; j++) begin : g_sup
    assign next_supply[j] =
      regs[SUP_REG[j]][SUP_POS[j]] &
      ~(regs[SUP_REG[j]][SUP_POS[j] + 5'h1] & stby_lvl);

    supply_gate_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !power_off_reset_low)
      ce && !regs[SUP_REG[j]][SUP_POS[j]] |=> !supply_on[j]
    ) else $error("supply on without its enable");

    supply_steady_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !power_off_reset_low)
      ce && regs[SUP_REG[j]][SUP_POS[j]] && !(regs[SUP_REG[j]][SUP_POS[j] + 5'h1] && stby_lvl)
      |=> supply_on[j]
    ) else $error("enabled supply failed to turn on");

    supply_standby_a: assert property (
      @(posedge core_clk) disable iff (!rst_n || !power_off_reset_low)
      ce && stby_lvl && regs[SUP_REG[j]][SUP_POS[j] + 5'h1] |=> !supply_on[j]
    ) else $error("standby-controlled supply stayed on");
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !power_off_reset_low) begin
      supply_on <= 15'h0000;
    end else if (ce) begin
      supply_on <= next_supply;
    end
  end

  // ==========================================
  // Field outputs, straight from the register flops
  assign third_switcher_op_mode       = regs[IDX_SW][`RCR_SW3_MODE_LSB +: 4];
  assign fourth_switcher_op_mode      = regs[IDX_SW][`RCR_SW4_MODE_LSB +: 4];
  assign third_switcher_memory_hold   = regs[IDX_SW][`RCR_SW3_HOLD_BIT];
  assign fourth_switcher_memory_hold  = regs[IDX_SW][`RCR_SW4_HOLD_BIT];
  assign third_switcher_user_off      = regs[IDX_SW][`RCR_SW3_UOFF_BIT];
  assign fourth_switcher_user_off     = regs[IDX_SW][`RCR_SW4_UOFF_BIT];
  assign boost_switcher_enable        = regs[IDX_SW][`RCR_BOOST_EN_BIT];
  assign voltage_select_a             = regs[1];
  assign voltage_select_b             = regs[2];
  assign short_circuit_protect_enable = regs[IDX_MISC][`RCR_SCP_EN_BIT];
  assign general_ldo3_external_pass   = regs[IDX_VIDB][`RCR_LDO3_EXT_BIT];
  assign camera_ldo_external_pass     = regs[IDX_VIDB][`RCR_CAM_EXT_BIT];
  assign video_ldo_op_mode            = regs[IDX_VIDB][`RCR_VID_MODE_BIT];

  // ==========================================
  // Assertions
  mode_load_a: assert property (
    @(posedge core_clk) disable iff (!rst_n || !power_off_reset_low)
    seq_load && !(wr_stb && addr == `RCR_OFF_SW_MODE_B)
    |=> third_switcher_op_mode == $past(seq_mode3)
        && fourth_switcher_op_mode == $past(seq_mode4)
  ) else $error("switcher mode not loaded by sequencer");

  mode_hold_a: assert property (
    @(posedge core_clk) disable iff (!rst_n || !power_off_reset_low)
    startup_done && !(wr_stb && addr == `RCR_OFF_SW_MODE_B)
    |=> $stable(third_switcher_op_mode) && $stable(fourth_switcher_op_mode)
  ) else $error("switcher mode changed without a write");

  hold_survive_a: assert property (
    @(posedge core_clk) disable iff (!power_off_reset_low)
    !rst_n |=> third_switcher_memory_hold == $past(third_switcher_memory_hold)
        && fourth_switcher_user_off == $past(fourth_switcher_user_off)
  ) else $error("memory hold or user off lost on main reset");

  hold_clear_a: assert property (
    @(posedge core_clk)
    !power_off_reset_low |=> !third_switcher_memory_hold
        && !third_switcher_user_off && !fourth_switcher_memory_hold
  ) else $error("power-off reset left hold bits set");

  scp_reset_a: assert property (
    @(posedge core_clk) disable iff (!power_off_reset_low)
    !rst_n |=> !short_circuit_protect_enable
  ) else $error("protection enable not cleared by main reset");

  standby_off_a: assert property (
    @(posedge core_clk) disable iff (!rst_n || !power_off_reset_low)
    ce && stby_lvl && regs[3][1] |=> !supply_on[0]
  ) else $error("standby-controlled regulator stayed on");

  ext_pass_a: assert property (
    @(posedge core_clk) disable iff (!power_off_reset_low)
    !rst_n |=> !general_ldo3_external_pass && !camera_ldo_external_pass
  ) else $error("external pass select not cleared");

  output_reset_a: assert property (
    @(posedge core_clk) disable iff (!power_off_reset_low)
    !rst_n |=> regs[IDX_MISC][13:6] == 8'h00 ##1 supply_on[14:11] == 4'h0
  ) else $error("general output bits not cleared");

  video_reset_a: assert property (
    @(posedge core_clk) disable iff (!power_off_reset_low)
    !rst_n |=> regs[IDX_VIDB][14:12] == 3'h0 && !video_ldo_op_mode
  ) else $error("video regulator bits not cleared");

  unused_zero_a: assert property (
    @(posedge core_clk) disable iff (!rst_n || !power_off_reset_low)
    ce && rd_stb && addr == `RCR_OFF_SW_MODE_B
    |=> rd_data[23:21] == 3'h0 && rd_data[19:14] == 6'h00
        && rd_data[7:6] == 2'h0
  ) else $error("unused bits read back nonzero");

  read_slot_a: assert property (
    @(posedge core_clk) disable iff (!rst_n || !power_off_reset_low)
    ce && !rd_stb |=> rd_data == 24'h000000
  ) else $error("read data outside its slot");

  unmapped_read_a: assert property (
    @(posedge core_clk) disable iff (!rst_n || !power_off_reset_low)
    ce && rd_stb && (addr < `RCR_OFF_SW_MODE_B || addr > `RCR_OFF_MISC)
    |=> rd_data == 24'h000000
  ) else $error("unmapped address read back nonzero");

  mode_default_a: assert property (
    @(posedge core_clk) disable iff (!power_off_reset_low)
    !rst_n |=> third_switcher_op_mode == DF[IDX_SW][`RCR_SW3_MODE_LSB +: 4]
        && fourth_switcher_op_mode == DF[IDX_SW][`RCR_SW4_MODE_LSB +: 4]
  ) else $error("main reset did not restore switcher modes");

  load_pulse_a: assert property (
    @(posedge core_clk) disable iff (!rst_n || !power_off_reset_low)
    seq_load |=> !seq_load
  ) else $error("sequencer load lasted more than one cycle");

  hold_load_a: assert property (
    @(posedge core_clk) disable iff (!rst_n || !power_off_reset_low)
    seq_load && !(wr_stb && addr == `RCR_OFF_SW_MODE_B)
    |=> $stable(third_switcher_memory_hold) && $stable(fourth_switcher_user_off)
  ) else $error("sequencer load disturbed hold or user off");

  supply_reset_a: assert property (
    @(posedge core_clk) disable iff (!power_off_reset_low)
    !rst_n |=> supply_on == 15'h0000
  ) else $error("supplies not off after main reset");

  standby_filter_a: assert property (
    @(posedge core_clk) disable iff (!power_off_reset_low)
    $changed(stby_lvl) |-> $past(stby_s2) == $past(stby_s3)
        && stby_lvl == $past(stby_s3)
  ) else $error("standby level taken before its stages agreed");

endmodule : rcr_regbank

//--- test_regulator_control_registers.sv
`timescale 1ns/1ns
`include "rcr_params.svh"
module test_regulator_control_registers;
  import rcr_pkg::*;

  // ==========================================
  // Stimulus and observed signals
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        por_n = 1'b0;
  logic        standby_pin = 1'b0;
  logic [1:0]  strap_sel = 2'h3;
  logic [5:0]  addr = 6'h00;
  logic [23:0] wr_data = 24'h000000;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [23:0] rd_data;
  logic [3:0]  mode3, mode4;
  logic        hold3, hold4, uoff3, uoff4, boost, scp, ldo3_ext, cam_ext, vid_mode, done;
  logic [23:0] vsel_a, vsel_b;
  logic [14:0] supply_on;
  int          mismatches = 0;
  int          checks_done = 0;
  logic [5:0]  offs [6] = '{6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22};
  logic [23:0] wm [6] = '{`RCR_WM_SW_MODE_B, `RCR_WM_VSEL_A, `RCR_WM_VSEL_B,
                          `RCR_WM_EN_MODE_A, `RCR_WM_EN_MODE_B, `RCR_WM_MISC};
  logic [23:0] rm [6] = '{`RCR_RM_SW_MODE_B, `RCR_RM_VSEL_A, `RCR_RM_VSEL_B,
                          `RCR_RM_EN_MODE_A, `RCR_RM_EN_MODE_B, `RCR_RM_MISC};
  logic [23:0] df [6] = '{`RCR_DF_SW_MODE_B, `RCR_DF_VSEL_A, `RCR_DF_VSEL_B,
                          `RCR_DF_EN_MODE_A, `RCR_DF_EN_MODE_B, `RCR_DF_MISC};

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end

  always #50 core_clk = ~core_clk;

  rcr_regbank uut (
    .core_clk                    (core_clk),
    .rst_n                       (rst_n),
    .ce                          (ce),
    .power_off_reset_low         (por_n),
    .standby_pin                 (standby_pin),
    .power_up_mode_select        (strap_sel),
    .addr                        (addr),
    .wr_data                     (wr_data),
    .wr_stb                      (wr_stb),
    .rd_stb                      (rd_stb),
    .rd_data                     (rd_data),
    .third_switcher_op_mode      (mode3),
    .fourth_switcher_op_mode     (mode4),
    .third_switcher_memory_hold  (hold3),
    .fourth_switcher_memory_hold (hold4),
    .third_switcher_user_off     (uoff3),
    .fourth_switcher_user_off    (uoff4),
    .boost_switcher_enable       (boost),
    .voltage_select_a            (vsel_a),
    .voltage_select_b            (vsel_b),
    .short_circuit_protect_enable(scp),
    .general_ldo3_external_pass  (ldo3_ext),
    .camera_ldo_external_pass    (cam_ext),
    .video_ldo_op_mode           (vid_mode),
    .supply_on                   (supply_on),
    .startup_done                (done)
  );

  // ==========================================
  // Bus and reset helpers
  task automatic bus_write(input logic [5:0] a, input logic [23:0] d);
    @(posedge core_clk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge core_clk);
    wr_stb  <= 1'b0;
  endtask : bus_write

  // Read word stands only in the cycle after the strobe, then falls to zero
  task automatic bus_read(input logic [5:0] a, output logic [23:0] d);
    @(posedge core_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 d = rd_data;
    @(posedge core_clk);
    #1 `CHK(rd_data, 24'h000000)
  endtask : bus_read

  task automatic do_reset(input logic full, input logic [1:0] strap);
    int i;
    @(posedge core_clk);
    rst_n <= 1'b0;
    por_n <= ~full;
    strap_sel <= strap;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    // Sequencer needs settle plus strap sync; bounded wait catches a hang
    for (i = 0; i < 40; i++) begin
      @(posedge core_clk);
      #1;
      if (done === 1'b1) break;
    end
    `CHK(done, 1'b1)
  endtask : do_reset

  // ==========================================
  // Scenarios
  task automatic test_defaults();
    logic [23:0] d;
    do_reset(1'b1, 2'h3);
    for (int i = 0; i < 6; i++) begin
      bus_read(offs[i], d);
      `CHK(d, df[i])
    end
    `CHK({mode4, mode3}, {`RCR_MODE_PWM, `RCR_MODE_PWM})
    `CHK({scp, ldo3_ext, cam_ext, vid_mode, supply_on}, 19'h00000)
    bus_read(6'h23, d);
    `CHK(d, 24'h000000)
  endtask : test_defaults

  task automatic test_all_ones();
    logic [23:0] d;
    for (int i = 0; i < 6; i++) bus_write(offs[i], 24'hffffff);
    bus_write(6'h23, 24'hffffff);
    for (int i = 0; i < 6; i++) begin
      bus_read(offs[i], d);
      `CHK(d, wm[i])
    end
    bus_read(6'h23, d);
    `CHK(d, 24'h000000)
    `CHK({hold3, hold4, uoff3, uoff4, boost}, 5'h1f)
    `CHK({scp, ldo3_ext, cam_ext, vid_mode}, 4'hf)
    `CHK({vsel_a, vsel_b}, {wm[1], wm[2]})
    // Frozen clock enable must drop the strobe
    @(posedge core_clk);
    ce <= 1'b0;
    bus_write(6'h22, 24'h000000);
    ce <= 1'b1;
    bus_read(6'h22, d);
    `CHK(d, wm[5])
  endtask : test_all_ones

  task automatic test_main_reset();
    logic [23:0] d;
    logic [23:0] e;
    do_reset(1'b0, 2'h1);
    for (int i = 0; i < 6; i++) begin
      e = (wm[i] & ~rm[i]) | (df[i] & rm[i]);
      if (i == 0) e = {e[23:12], `RCR_MODE_OFF, e[7:4], `RCR_MODE_PWM};
      bus_read(offs[i], d);
      `CHK(d, e)
    end
    `CHK({hold3, hold4, uoff3, uoff4}, 4'hf)
    `CHK(scp, 1'b0)
    `CHK({ldo3_ext, cam_ext, vid_mode}, 3'h0)
  endtask : test_main_reset

  task automatic test_strap_modes();
    logic [3:0] m3;
    logic [3:0] m4;
    for (int s = 0; s < 4; s++) begin
      do_reset(1'b1, s[1:0]);
      m3 = (s != 0) ? `RCR_MODE_PWM : `RCR_MODE_OFF;
      m4 = s[1] ? `RCR_MODE_PWM : `RCR_MODE_OFF;
      `CHK({mode4, mode3}, {m4, m3})
      `CHK({hold3, hold4, uoff3, uoff4}, 4'h0)
    end
  endtask : test_strap_modes

  task automatic test_standby();
    // Regulator 0 and video and output 0 follow standby, regulator 1 does not
    bus_write(6'h20, 24'h00000b);
    bus_write(6'h21, 24'h003000);
    bus_write(6'h22, 24'h0000c0);
    repeat (2) @(posedge core_clk);
    #1 `CHK(supply_on, 15'h0903)
    @(posedge core_clk);
    standby_pin <= 1'b1;
    repeat (7) @(posedge core_clk);
    #1 `CHK(supply_on, 15'h0002)
    @(posedge core_clk);
    standby_pin <= 1'b0;
    repeat (7) @(posedge core_clk);
    #1 `CHK(supply_on, 15'h0903)
    do_reset(1'b0, 2'h3);
    // Supply 1 enable has no main reset, so only it stays on
    `CHK(supply_on, 15'h0002)
  endtask : test_standby

  // ==========================================
  // Verdict
  task automatic test_done();
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    test_defaults();
    test_all_ones();
    test_main_reset();
    test_strap_modes();
    test_standby();
    test_done();
  end

  // Whole run is well under a thousand cycles; this limit only cuts a hang
  initial begin
    #(5000 * 100);
    mismatches++;
    test_done();
  end

endmodule : test_regulator_control_registers
